// File: logic/fwpg_consts.svh
// Purpose: shared constants of the flash write-protection gate
// Assumes: core clock at 10 MHz, SPI mode 0 on the serial link
// Notes: bit positions index protection_register, config_register, status_register_3
//
// Functional notes
// - Below minimum supply every instruction is ignored and operations stay disabled; the serial link still answers status reads (05h, 0Fh).
// - After supply valid and select delay, write-type instructions refused for powerup_write_delay.
// - Power-up leaves write_enable_latch cleared.
// - Program or erase needs a prior Write Enable; refused while latch clear.
// - Completion of program or erase clears write_enable_latch.
// - Hardware protect enabled with write-protect pin low blocks every write, program, erase.
// - Hardware protect enabled disables all quad operations.
// - Three status registers, selected by a one-byte register address.
// - Opcodes 05h and 0Fh both read a status register.
// - Status writes obey register-protect bits, Write Enable, and pin in hardware mode; config_register writes skip the register-protect bits.
// - protection_register layout: bit7 protect-lo, 6..3 block protect, 2 top/bottom, 1 hw, 0 protect-hi.
// - Block protect bits are writable and shield their selected array region.
// - Power-up sets every block protection bit to one.
// - With protection_lock_bit set, power-up loads the locked protection values.
// - Hardware protect clear: software mode, pins double as data, quad enabled.
// - Hardware protect set: protect and pause pins are dedicated inputs only.
// - Software mode, protect bits (0,1): pin low refuses protection_register changes.
// - Protect bits (1,0) lock protection_register until a power cycle returns (0,0).
// - protection_lock_bit sets only with both protect bits one and otp access on.
`ifndef FWPG_CONSTS_SVH
`define FWPG_CONSTS_SVH

`define FWPG_CLK_FREQ_MHZ    10
`define FWPG_VSL_TIME_US     10
`define FWPG_PUW_TIME_US     1000

`define FWPG_OP_WR_ENABLE    8'h06
`define FWPG_OP_WR_DISABLE   8'h04
`define FWPG_OP_RD_STATUS_A  8'h05
`define FWPG_OP_RD_STATUS_B  8'h0F
`define FWPG_OP_WR_STATUS_A  8'h01
`define FWPG_OP_WR_STATUS_B  8'h1F
`define FWPG_OP_PROG_EXEC    8'h10
`define FWPG_OP_BLOCK_ERASE  8'hD8
`define FWPG_OP_QUAD_LOAD_A  8'h32
`define FWPG_OP_QUAD_LOAD_B  8'h34
`define FWPG_OP_QUAD_OUT_A   8'h6B
`define FWPG_OP_QUAD_OUT_B   8'h6C
`define FWPG_OP_QUAD_IO_A    8'hEB
`define FWPG_OP_QUAD_IO_B    8'hEC

`define FWPG_ADDR_PROT       4'hA
`define FWPG_ADDR_CFG        4'hB
`define FWPG_ADDR_SR3        4'hC

`define FWPG_PROT_RP_LO      7
`define FWPG_PROT_BP_HI      6
`define FWPG_PROT_BP_LO      3
`define FWPG_PROT_TB         2
`define FWPG_PROT_HWPE       1
`define FWPG_PROT_RP_HI      0
`define FWPG_CFG_OTP_LOCK    7
`define FWPG_CFG_OTP_ACCESS  6
`define FWPG_CFG_PROT_LOCK   5
`define FWPG_SR3_BUSY        0
`define FWPG_SR3_WEL         1
`define FWPG_SR3_ERASE_FAIL  2
`define FWPG_SR3_PROG_FAIL   3

`define FWPG_PROT_RESET      8'h7C
`define FWPG_CFG_RESET       8'h10
`define FWPG_PAGE_AW         18
`define FWPG_BP_GRAN_PAGES   256
`define FWPG_PE_BYTES        3'h4
`define FWPG_WSR_BYTES       3'h3

`endif

// File: logic/fwpg_pkg.sv
// Purpose: types of the flash write-protection gate
// Assumes: nothing
// Notes: status word packs protection, config, status_register_3 low to high
`default_nettype none
package fwpg_pkg;
  typedef enum logic [1:0] {PWR_OFF, PWR_VSL, PWR_PUW, PWR_ON} fwpg_pwr_t;
  typedef logic [7:0]  fwpg_byte_t;
  typedef logic [23:0] fwpg_status_t;
endpackage
`default_nettype wire

// File: logic/fwpg_spi_link.sv
// Purpose: serial-clock side of the gate: byte capture and status read-out
// Assumes: SPI mode 0, sclk only toggles while chip select is low
// Notes: bytes go to the core by toggle, status words arrive by req/ack handshake
`timescale 1ns/1ns
`default_nettype none
`include "fwpg_consts.svh"
module fwpg_spi_link (
  input  wire logic                   sclk_i,
  input  wire logic                   cs_b_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   mosi_i,
  input  wire fwpg_pkg::fwpg_status_t shadow_i,
  input  wire logic                   req_i,
  output logic                        ack_o,
  output fwpg_pkg::fwpg_byte_t        byte_o,
  output logic                        byte_tgl_o,
  output logic                        miso_o,
  output logic                        miso_oe_o
);
  import fwpg_pkg::*;

  logic         frame_rst_b;
  logic [2:0]   bit_cnt_reg;
  logic [6:0]   shift_reg;
  logic [1:0]   byte_idx_reg;
  fwpg_byte_t   op_reg;
  fwpg_byte_t   addr_reg;
  fwpg_status_t shadow_cap_reg;
  logic         req_s;
  fwpg_byte_t   full_byte;
  fwpg_byte_t   sel_byte;
  logic         rd_act;
  logic         byte_end;

  // frame logic is cleared whenever the chip is deselected
  assign frame_rst_b = rst_b_i & ~cs_b_i;
  assign full_byte   = {shift_reg, mosi_i};
  assign byte_end    = (bit_cnt_reg == 3'h7);
  assign rd_act      = ((op_reg == `FWPG_OP_RD_STATUS_A) || (op_reg == `FWPG_OP_RD_STATUS_B))
                       && (byte_idx_reg >= 2'h2);
  assign sel_byte    = (addr_reg[7:4] == `FWPG_ADDR_PROT) ? shadow_cap_reg[7:0]   :
                       (addr_reg[7:4] == `FWPG_ADDR_CFG)  ? shadow_cap_reg[15:8]  :
                       (addr_reg[7:4] == `FWPG_ADDR_SR3)  ? shadow_cap_reg[23:16] : 8'h00;

  fwpg_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_req_sync (
    .clk_i   (sclk_i),
    .rst_b_i (rst_b_i),
    .async_i (req_i),
    .sync_o  (req_s)
  );

  always_ff @(posedge sclk_i or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 7'h00;
      byte_idx_reg <= 2'h0;
      op_reg       <= 8'h00;
      addr_reg     <= 8'h00;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= full_byte[6:0];
      if (byte_end && byte_idx_reg == 2'h0)
        op_reg <= full_byte;
      if (byte_end && byte_idx_reg == 2'h1)
        addr_reg <= full_byte;
      if (byte_end && byte_idx_reg != 2'h3)
        byte_idx_reg <= byte_idx_reg + 2'h1;
    end
  end

  // byte hand-off and status shadow survive deselect
  always_ff @(posedge sclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      byte_o         <= 8'h00;
      byte_tgl_o     <= 1'b0;
      shadow_cap_reg <= 24'h000000;
      ack_o          <= 1'b0;
    end
    else
    begin
      if (byte_end)
      begin
        byte_o     <= full_byte;
        byte_tgl_o <= ~byte_tgl_o;
      end
      if (req_s != ack_o)
      begin
        shadow_cap_reg <= shadow_i;
        ack_o          <= req_s;
      end
    end
  end

  // read data leaves on the falling edge, msb first
  always_ff @(negedge sclk_i or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end
    else
    begin
      miso_o    <= sel_byte[3'h7 - bit_cnt_reg];
      miso_oe_o <= rd_act;
    end
  end
endmodule
`default_nettype wire

// File: logic/fwpg_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: inputs are slow levels or toggles
// Notes: first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module fwpg_sync #(
  parameter int unsigned     WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: logic/fwpg_top.sv
// Purpose: write-protection gate of a serial NAND flash
// Assumes: array core on core_clk_i, serial link on its own clock
// Notes: commands execute at the rising edge of chip select
`timescale 1ns/1ns
`default_nettype none
`include "fwpg_consts.svh"
module fwpg_top #(
  parameter int unsigned VSL_CYCLES = `FWPG_VSL_TIME_US * `FWPG_CLK_FREQ_MHZ,
  parameter int unsigned PUW_CYCLES = `FWPG_PUW_TIME_US * `FWPG_CLK_FREQ_MHZ
)(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     supply_good_i,
  input  wire logic                     sclk_i,
  input  wire logic                     cs_b_i,
  input  wire logic                     mosi_i,
  input  wire logic                     wp_b_i,
  input  wire logic                     array_done_i,
  input  wire logic                     array_fail_i,
  output logic                          miso_o,
  output logic                          miso_oe_o,
  output logic                          array_start_o,
  output logic                          array_erase_o,
  output logic     [`FWPG_PAGE_AW-1:0]  array_page_o,
  output logic                          cmd_reject_o,
  output logic                          quad_allowed_o,
  output logic                          pins_dedicated_o
);
  import fwpg_pkg::*;

  localparam int unsigned          AW          = `FWPG_PAGE_AW;
  localparam longint unsigned      TOTAL       = longint'(1) << AW;
  localparam logic [AW:0]          TOTAL_W     = (AW+1)'(TOTAL);

  fwpg_pwr_t    pwr_state_reg;
  fwpg_pwr_t    pwr_state_next;
  logic [31:0]  timer_reg;
  logic [31:0]  timer_next;
  logic [4:0]   sync_in;
  logic [4:0]   sync_out;
  logic         supply_s;
  logic         cs_s;
  logic         wp_s;
  logic         tgl_s;
  logic         ack_s;
  logic         ack_link;
  logic         tgl_d_reg;
  logic         cs_d_reg;
  logic         exec_reg;
  logic [2:0]   byte_cnt_reg;
  fwpg_byte_t   cmd_bytes_reg [4];
  fwpg_byte_t   link_byte;
  logic         link_tgl;
  fwpg_byte_t   prot_reg;
  fwpg_byte_t   cfg_reg;
  fwpg_byte_t   locked_prot_reg;
  fwpg_byte_t   sr3;
  fwpg_byte_t   cfg_wr_val;
  logic         wel_reg;
  logic         busy_reg;
  logic         prog_fail_reg;
  logic         erase_fail_reg;
  fwpg_status_t live_status;
  fwpg_status_t shadow_reg;
  logic         req_reg;
  logic [AW:0]  span_tbl [16];
  logic [AW:0]  span;
  logic [AW:0]  page_w;
  fwpg_byte_t   op;
  logic         is_wren;
  logic         is_wrdi;
  logic         is_wsr;
  logic         is_pe;
  logic         is_quad;
  logic         byte_start;
  logic         cs_rise;
  logic         cmd_live;
  logic         hw_mode;
  logic         hw_block;
  logic         guard;
  logic         zone_hit;
  logic         wren_ok;
  logic         pe_ok;
  logic         prot_wr_ok;
  logic         cfg_wr_ok;
  logic         plock_ok;
  logic         reject;

  assign sync_in = {supply_good_i, cs_b_i, wp_b_i, link_tgl, ack_link};

  fwpg_sync #(.WIDTH(5), .RST_VAL(5'h08)) u_pin_sync (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_b_i),
    .async_i (sync_in),
    .sync_o  (sync_out)
  );

  fwpg_spi_link u_link (
    .sclk_i     (sclk_i),
    .cs_b_i     (cs_b_i),
    .rst_b_i    (rst_b_i),
    .mosi_i     (mosi_i),
    .shadow_i   (shadow_reg),
    .req_i      (req_reg),
    .ack_o      (ack_link),
    .byte_o     (link_byte),
    .byte_tgl_o (link_tgl),
    .miso_o     (miso_o),
    .miso_oe_o  (miso_oe_o)
  );

  assign supply_s = sync_out[4];
  assign cs_s     = sync_out[3];
  assign wp_s     = sync_out[2];
  assign tgl_s    = sync_out[1];
  assign ack_s    = sync_out[0];

  // power sequencing: off, select delay, write lockout, on
  always_comb
  begin
    pwr_state_next = pwr_state_reg;
    timer_next     = timer_reg + 32'h1;
    case (pwr_state_reg)
      PWR_OFF:
      begin
        timer_next = 32'h0;
        if (supply_s)
          pwr_state_next = PWR_VSL;
      end
      PWR_VSL:
        if (timer_reg >= VSL_CYCLES - 1)
        begin
          pwr_state_next = PWR_PUW;
          timer_next     = 32'h0;
        end
      PWR_PUW:
        if (timer_reg >= PUW_CYCLES - 1)
          pwr_state_next = PWR_ON;
      default:
        timer_next = 32'h0;
    endcase
    if (!supply_s)
      pwr_state_next = PWR_OFF;
  end

  // block protect code to protected span of pages
  for (genvar k = 0; k < 16; k++)
  begin : g_span
    localparam longint unsigned RAW = (k == 0) ? 0 : (longint'(`FWPG_BP_GRAN_PAGES) << (k - 1));
    localparam longint unsigned CAP = (RAW > TOTAL) ? TOTAL : RAW;
    assign span_tbl[k] = (AW+1)'(CAP);
  end

  assign cmd_live   = (pwr_state_reg == PWR_PUW) || (pwr_state_reg == PWR_ON);
  assign byte_start = tgl_s ^ tgl_d_reg;
  assign cs_rise    = cs_s & ~cs_d_reg;
  assign op         = cmd_bytes_reg[0];
  assign is_wren    = (op == `FWPG_OP_WR_ENABLE);
  assign is_wrdi    = (op == `FWPG_OP_WR_DISABLE);
  assign is_wsr     = ((op == `FWPG_OP_WR_STATUS_A) || (op == `FWPG_OP_WR_STATUS_B))
                      && (byte_cnt_reg >= `FWPG_WSR_BYTES);
  assign is_pe      = ((op == `FWPG_OP_PROG_EXEC) || (op == `FWPG_OP_BLOCK_ERASE));
  assign is_quad    = (op == `FWPG_OP_QUAD_LOAD_A) || (op == `FWPG_OP_QUAD_LOAD_B)
                      || (op == `FWPG_OP_QUAD_OUT_A) || (op == `FWPG_OP_QUAD_OUT_B)
                      || (op == `FWPG_OP_QUAD_IO_A) || (op == `FWPG_OP_QUAD_IO_B);
  assign hw_mode    = prot_reg[`FWPG_PROT_HWPE];
  assign hw_block   = hw_mode & ~wp_s;
  assign guard      = (pwr_state_reg != PWR_ON) | hw_block | busy_reg;
  assign page_w     = {1'b0, (AW)'({cmd_bytes_reg[1], cmd_bytes_reg[2], cmd_bytes_reg[3]})};
  assign span       = span_tbl[prot_reg[`FWPG_PROT_BP_HI:`FWPG_PROT_BP_LO]];
  assign zone_hit   = (span != '0) && (prot_reg[`FWPG_PROT_TB] ? (page_w < span)
                                                               : (page_w >= TOTAL_W - span));
  assign wren_ok    = is_wren & ~guard;
  assign pe_ok      = is_pe & (byte_cnt_reg >= `FWPG_PE_BYTES) & wel_reg & ~guard & ~zone_hit;
  assign prot_wr_ok = is_wsr & (cmd_bytes_reg[1][7:4] == `FWPG_ADDR_PROT) & wel_reg & ~guard
                      & ~cfg_reg[`FWPG_CFG_PROT_LOCK]
                      & ~(prot_reg[`FWPG_PROT_RP_HI] & ~prot_reg[`FWPG_PROT_RP_LO])
                      & ~(~hw_mode & ~prot_reg[`FWPG_PROT_RP_HI]
                          & prot_reg[`FWPG_PROT_RP_LO] & ~wp_s);
  assign cfg_wr_ok  = is_wsr & (cmd_bytes_reg[1][7:4] == `FWPG_ADDR_CFG) & wel_reg & ~guard;
  assign plock_ok   = prot_reg[`FWPG_PROT_RP_HI] & prot_reg[`FWPG_PROT_RP_LO]
                      & cfg_reg[`FWPG_CFG_OTP_ACCESS];
  assign reject     = exec_reg & ((is_pe & ~pe_ok) | (is_wsr & ~prot_wr_ok & ~cfg_wr_ok)
                                  | (is_wren & ~wren_ok) | (is_quad & hw_mode));

  // lock bits only ever set; protection lock needs the otp unlock state
  always_comb
  begin
    cfg_wr_val = cmd_bytes_reg[2];
    cfg_wr_val[`FWPG_CFG_OTP_LOCK]  = cfg_reg[`FWPG_CFG_OTP_LOCK] | cmd_bytes_reg[2][`FWPG_CFG_OTP_LOCK];
    cfg_wr_val[`FWPG_CFG_PROT_LOCK] = cfg_reg[`FWPG_CFG_PROT_LOCK]
                                      | (cmd_bytes_reg[2][`FWPG_CFG_PROT_LOCK] & plock_ok);
  end

  always_comb
  begin
    sr3 = 8'h00;
    sr3[`FWPG_SR3_BUSY]       = busy_reg;
    sr3[`FWPG_SR3_WEL]        = wel_reg;
    sr3[`FWPG_SR3_ERASE_FAIL] = erase_fail_reg;
    sr3[`FWPG_SR3_PROG_FAIL]  = prog_fail_reg;
  end

  assign live_status = {sr3, cfg_reg, prot_reg};

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pwr_state_reg <= PWR_OFF;
      timer_reg     <= 32'h0;
      tgl_d_reg     <= 1'b0;
      cs_d_reg      <= 1'b1;
      exec_reg      <= 1'b0;
      shadow_reg    <= 24'h000000;
      req_reg       <= 1'b0;
    end
    else
    begin
      pwr_state_reg <= pwr_state_next;
      timer_reg     <= timer_next;
      tgl_d_reg     <= tgl_s;
      cs_d_reg      <= cs_s;
      exec_reg      <= cs_rise & cmd_live & (byte_cnt_reg != 3'h0);
      if ((req_reg == ack_s) && (live_status != shadow_reg))
      begin
        shadow_reg <= live_status;
        req_reg    <= ~req_reg;
      end
    end
  end

  // instruction bytes collected per frame
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      byte_cnt_reg <= 3'h0;
      for (int i = 0; i < 4; i++)
        cmd_bytes_reg[i] <= 8'h00;
    end
    else if (byte_start && byte_cnt_reg < `FWPG_PE_BYTES)
    begin
      cmd_bytes_reg[byte_cnt_reg[1:0]] <= link_byte;
      byte_cnt_reg                     <= byte_cnt_reg + 3'h1;
    end
    else if (cs_s && cs_d_reg)
      byte_cnt_reg <= 3'h0;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prot_reg        <= `FWPG_PROT_RESET;
      cfg_reg         <= `FWPG_CFG_RESET;
      locked_prot_reg <= `FWPG_PROT_RESET;
      wel_reg         <= 1'b0;
      busy_reg        <= 1'b0;
      prog_fail_reg   <= 1'b0;
      erase_fail_reg  <= 1'b0;
    end
    else if (pwr_state_reg == PWR_OFF)
    begin
      // power cycle: volatile bits except the fail flags back to defaults, otp lock and protection lock bits kept
      prot_reg <= cfg_reg[`FWPG_CFG_PROT_LOCK] ? locked_prot_reg : `FWPG_PROT_RESET;
      cfg_reg  <= (`FWPG_CFG_RESET & ~8'hA0) | (cfg_reg & 8'hA0);
      wel_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      if (exec_reg && prot_wr_ok)
        prot_reg <= cmd_bytes_reg[2];
      if (exec_reg && cfg_wr_ok)
        cfg_reg <= cfg_wr_val;
      if (exec_reg && cfg_wr_ok && plock_ok && cmd_bytes_reg[2][`FWPG_CFG_PROT_LOCK])
        locked_prot_reg <= prot_reg;
      if (busy_reg && array_done_i)
        wel_reg <= 1'b0;
      else if (exec_reg && wren_ok)
        wel_reg <= 1'b1;
      else if (exec_reg && is_wrdi)
        wel_reg <= 1'b0;
      if (exec_reg && pe_ok)
      begin
        busy_reg       <= 1'b1;
        prog_fail_reg  <= 1'b0;
        erase_fail_reg <= 1'b0;
      end
      else if (busy_reg && array_done_i)
      begin
        busy_reg       <= 1'b0;
        prog_fail_reg  <= array_fail_i & ~array_erase_o;
        erase_fail_reg <= array_fail_i & array_erase_o;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      array_start_o    <= 1'b0;
      array_erase_o    <= 1'b0;
      array_page_o     <= '0;
      cmd_reject_o     <= 1'b0;
      quad_allowed_o   <= 1'b1;
      pins_dedicated_o <= 1'b0;
    end
    else
    begin
      array_start_o    <= exec_reg & pe_ok;
      cmd_reject_o     <= reject;
      quad_allowed_o   <= ~hw_mode;
      pins_dedicated_o <= hw_mode;
      if (exec_reg && pe_ok)
      begin
        array_erase_o <= (op == `FWPG_OP_BLOCK_ERASE);
        array_page_o  <= page_w[AW-1:0];
      end
    end
  end

  a_off_no_start: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (pwr_state_reg == PWR_OFF || pwr_state_reg == PWR_VSL) |=> !array_start_o && !exec_reg)
    else $error("operation started without valid supply");

  a_puw_no_wel: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (pwr_state_reg == PWR_PUW && !wel_reg) |=> !wel_reg)
    else $error("write enable accepted during power-up lockout");

  a_pwrup_defaults: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (pwr_state_reg == PWR_OFF) |=> !wel_reg && !busy_reg)
    else $error("latch not cleared at power-up");

  a_bp_all_set: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (pwr_state_reg == PWR_OFF && !cfg_reg[`FWPG_CFG_PROT_LOCK]) |=> prot_reg == `FWPG_PROT_RESET)
    else $error("block protection not set after power-up");

  a_start_needs_wel: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    array_start_o |-> $past(wel_reg) && wel_reg && busy_reg)
    else $error("array started without write enable");

  a_done_clears_wel: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (busy_reg && array_done_i && pwr_state_reg != PWR_OFF) |=> !wel_reg && !busy_reg)
    else $error("latch not cleared after completion");

  a_hw_blocks_all: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && hw_block && pwr_state_reg != PWR_OFF) |=> !array_start_o && $stable(prot_reg) && $stable(cfg_reg))
    else $error("write passed while hardware protected");

  a_quad_off_hw: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    hw_mode |=> !quad_allowed_o && pins_dedicated_o)
    else $error("quad still allowed in hardware mode");

  a_lockdown_hold: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (pwr_state_reg != PWR_OFF && prot_reg[`FWPG_PROT_RP_HI] && !prot_reg[`FWPG_PROT_RP_LO]) |=> $stable(prot_reg))
    else $error("protection register changed under lock-down");

  a_reject_quiet: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cmd_reject_o && $past(is_pe)) |-> !array_start_o && (wel_reg == $past(wel_reg)))
    else $error("rejected command disturbed the latch");

  a_lock_needs_otp: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(cfg_reg[`FWPG_CFG_PROT_LOCK]) |-> $past(plock_ok))
    else $error("protection lock set without otp unlock");
endmodule
`default_nettype wire

// File: tb/flash_write_protection_gate_bench.sv
// Purpose: self-checking bench of the write-protection gate
// Assumes: short power-up counts set by parameter
// Notes: pulse outputs are counted and compared per frame
`timescale 1ns/1ns
`default_nettype none
module flash_write_protection_gate_bench;
  import fwpg_pkg::*;
  logic core_clk_i = 0, rst_b_i = 0, supply_good_i = 1, wp_b_i = 1, array_done_i = 0, array_fail_i = 0;
  logic sclk_i, cs_b_i, mosi_i, miso_o, miso_oe_o, array_start_o, array_erase_o;
  logic cmd_reject_o, quad_allowed_o, pins_dedicated_o;
  logic [17:0] array_page_o;
  logic [7:0] n_st = 0, n_rj = 0;
  int n_fail = 0, checks = 0, cyc = 0;
  fwpg_top #(.VSL_CYCLES(4), .PUW_CYCLES(100)) dut (.core_clk_i, .rst_b_i, .supply_good_i, .sclk_i,
    .cs_b_i, .mosi_i, .wp_b_i, .array_done_i, .array_fail_i, .miso_o, .miso_oe_o, .array_start_o,
    .array_erase_o, .array_page_o, .cmd_reject_o, .quad_allowed_o, .pins_dedicated_o);
  fwpg_host host (.sclk_o(sclk_i), .cs_b_o(cs_b_i), .mosi_o(mosi_i), .miso_i(miso_o), .miso_oe_i(miso_oe_o));
  always #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    n_st <= n_st + array_start_o;
    n_rj <= n_rj + cmd_reject_o;
    if (cyc == 6000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // second frame reads back a settled status copy
  task automatic rd_reg(input logic [7:0] op, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] r;
    host.frame({8'h00, op, a, 12'h000}, 3, r);
    host.frame({8'h00, op, a, 12'h000}, 3, r);
    chk(r, exp);
  endtask
  // checks how many start and refusal pulses the frame produced
  task automatic cmd(input logic [31:0] d, input int n, input logic [7:0] dst, input logic [7:0] drj);
    logic [7:0] r, st0, rj0;
    st0 = n_st;
    rj0 = n_rj;
    host.frame(d, n, r);
    chk(n_st - st0, dst);
    chk(n_rj - rj0, drj);
  endtask
  // supply dip, then wait out select delay and write lockout
  task automatic pwr_cycle();
    @(negedge core_clk_i);
    supply_good_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
    supply_good_i = 1'b1;
    repeat (130) @(negedge core_clk_i);
  endtask
  initial
  begin
    repeat (20) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    repeat (8) @(negedge core_clk_i);
    cmd(32'h06, 1, 8'h00, 8'h01);
    repeat (120) @(negedge core_clk_i);
    rd_reg(8'h05, 4'hC, 8'h00);
    rd_reg(8'h05, 4'hA, 8'h7C);
    rd_reg(8'h0F, 4'hA, 8'h7C);
    chk({6'h00, quad_allowed_o, pins_dedicated_o}, 8'h02);
    cmd(32'h1000_0001, 4, 8'h00, 8'h01);
    cmd(32'h06, 1, 8'h00, 8'h00);
    rd_reg(8'h05, 4'hC, 8'h02);
    cmd(32'h1000_0001, 4, 8'h00, 8'h01);
    rd_reg(8'h0F, 4'hC, 8'h02);
    cmd(32'h1FA000, 3, 8'h00, 8'h00);
    rd_reg(8'h05, 4'hA, 8'h00);
    cmd(32'h1000_0001, 4, 8'h01, 8'h00);
    chk({array_erase_o, array_page_o[6:0]}, 8'h01);
    rd_reg(8'h05, 4'hC, 8'h03);
    @(negedge core_clk_i);
    array_done_i = 1'b1;
    array_fail_i = 1'b1;
    @(negedge core_clk_i);
    array_done_i = 1'b0;
    array_fail_i = 1'b0;
    rd_reg(8'h05, 4'hC, 8'h08);
    cmd(32'h06, 1, 8'h00, 8'h00);
    cmd(32'h01A002, 3, 8'h00, 8'h00);
    rd_reg(8'h05, 4'hA, 8'h02);
    chk({6'h00, quad_allowed_o, pins_dedicated_o}, 8'h01);
    @(negedge core_clk_i);
    wp_b_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    cmd(32'hD800_0002, 4, 8'h00, 8'h01);
    cmd(32'h01A000, 3, 8'h00, 8'h01);
    cmd(32'h6B00_0000, 4, 8'h00, 8'h01);
    rd_reg(8'h05, 4'hA, 8'h02);
    pwr_cycle();
    rd_reg(8'h05, 4'hA, 8'h7C);
    chk({6'h00, quad_allowed_o, pins_dedicated_o}, 8'h02);
    cmd(32'h01A080, 3, 8'h00, 8'h01);
    cmd(32'h06, 1, 8'h00, 8'h00);
    cmd(32'h01A080, 3, 8'h00, 8'h00);
    cmd(32'h01A000, 3, 8'h00, 8'h01);
    @(negedge core_clk_i);
    wp_b_i = 1'b1;
    cmd(32'h01A001, 3, 8'h00, 8'h00);
    cmd(32'h01A07C, 3, 8'h00, 8'h01);
    rd_reg(8'h05, 4'hA, 8'h01);
    pwr_cycle();
    rd_reg(8'h05, 4'hA, 8'h7C);
    stop_test();
  end
endmodule
`default_nettype wire

// File: tb/fwpg_host.sv
// Purpose: spi host model facing the gate
// Assumes: mode 0, 125 ns serial clock, msb first
// Notes: clock stands still between frames; idle mosi shows inverse of last bit
`timescale 1ns/1ns
`default_nettype none
module fwpg_host (
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    mosi_o = 1'b0;
  end
  // shifts n low bytes of d; rd keeps the last eight bits seen on miso
  task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    cs_b_o = 1'b0;
    #63;
    for (int i = 8 * n - 1; i >= 0; i--)
    begin
      mosi_o = d[i];
      #62 sclk_o = 1'b1;
      // undriven line reads inverted, so a missing enable shows up
      rd = {rd[6:0], miso_oe_i ? miso_i : ~miso_i};
      #63 sclk_o = 1'b0;
    end
    #63 cs_b_o = 1'b1;
    mosi_o = ~mosi_o;
    #1000;
  endtask
endmodule
`default_nettype wire
